// File: hdl/csf_status_reg.sv
// processor status register with flag protection and reset-cause bits
// How it works
// - any instruction may write file address of the status register
// - flag-updating instructions lose written zero, digit carry, carry
// - writes to timeout and power-down flags are ignored
// - clear-file zeroes upper three bits, sets zero, keeps others
// - bit set/clear and move-to-file write arithmetic flags from data, not from alu
// - eight bits at file address 03h, wake flag down to carry
// - wake (except on pin-change reset), unused, page reset 0; timeout, power-down reset 1
// - unimplemented bit reads zero
// - wake flag set on pin-change reset, cleared on others
// - page select picks program page 1 or 0 of 512 words
// - timeout set at power-up, watchdog clear, sleep; cleared on expiry
module csf_status_reg
  import csf_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  input  wire logic         pin_wake_reset_in,
  input  wire logic         write_en_in,
  input  wire logic [7:0]   write_addr_in,
  input  wire csf_wr_kind_t write_kind_in,
  input  wire logic [7:0]   write_data_in,
  input  wire logic         alu_flag_en_in,
  input  wire logic         alu_zero_in,
  input  wire logic         alu_dc_in,
  input  wire logic         alu_carry_in,
  input  wire logic         watchdog_clear_instr_in,
  input  wire logic         sleep_instr_in,
  input  wire logic         watchdog_timer_expired_in,
  input  wire logic [7:0]   read_addr_in,
  output logic [7:0]        read_data_out,
  output logic [7:0]        status_out,
  output logic              program_page_select_out,
  output logic [9:0]        page_base_out
);
  logic       pin_change_wake_flag_q;
  logic       pin_change_wake_flag_d;
  logic       program_page_select_q;
  logic       program_page_select_d;
  logic       watchdog_timeout_flag_q;
  logic       watchdog_timeout_flag_d;
  logic       power_down_flag_q;
  logic       power_down_flag_d;
  logic [2:0] arith_q;
  logic [2:0] arith_d;
  logic [7:0] read_data_q;

  wire hit       = write_en_in && (write_addr_in == CSF_FILE_ADDR);
  wire is_clear  = hit && (write_kind_in == CSF_WR_CLEAR);
  wire is_flag   = hit && (write_kind_in == CSF_WR_FLAGGED);
  wire is_plain  = hit && (write_kind_in == CSF_WR_PLAIN);

  wire [7:0] status_now = {pin_change_wake_flag_q,
                           1'b0,
                           program_page_select_q,
                           watchdog_timeout_flag_q,
                           power_down_flag_q,
                           arith_q};

  // clear-file takes the upper bits to zero; data path ignored for it
  assign pin_change_wake_flag_d = is_clear ? CSF_UPPER_CLEAR[2] :
                                  hit ? write_data_in[CSF_BIT_WAKE] :
                                  pin_change_wake_flag_q;
  assign program_page_select_d  = is_clear ? CSF_UPPER_CLEAR[0] :
                                  hit ? write_data_in[CSF_BIT_PAGE] :
                                  program_page_select_q;

  // on flag-updating writes the alu update wins over written data even when the status register is
  // the destination; zero/dc/carry cannot be forced by such instructions
  always_comb
  begin
    arith_d = arith_q;
    if (is_clear)
    begin
      arith_d[CSF_BIT_ZERO] = 1'b1;
    end
    else if (is_flag || (alu_flag_en_in && !is_plain))
    begin
      arith_d = alu_flag_en_in ?
                {alu_zero_in, alu_dc_in, alu_carry_in} : arith_q;
    end
    else if (is_plain)
    begin
      arith_d = write_data_in[CSF_BIT_ZERO:CSF_BIT_CARRY];
    end
  end

  // only core events move timeout and power-down; bus data never does
  always_comb
  begin
    watchdog_timeout_flag_d = watchdog_timeout_flag_q;
    power_down_flag_d       = power_down_flag_q;
    if (watchdog_timer_expired_in)
    begin
      watchdog_timeout_flag_d = 1'b0;
    end
    else if (watchdog_clear_instr_in)
    begin
      watchdog_timeout_flag_d = 1'b1;
      power_down_flag_d       = 1'b1;
    end
    else if (sleep_instr_in)
    begin
      watchdog_timeout_flag_d = 1'b1;
      power_down_flag_d       = 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pin_change_wake_flag_q  <= pin_wake_reset_in ? 1'b1 : CSF_RST_RW0;
      program_page_select_q   <= CSF_RST_RW0;
      watchdog_timeout_flag_q <= CSF_RST_RO1;
      power_down_flag_q       <= CSF_RST_RO1;
      arith_q                 <= {3{CSF_RST_ARITH}};
      read_data_q             <= 8'h00;
    end
    else
    begin
      pin_change_wake_flag_q  <= pin_change_wake_flag_d;
      program_page_select_q   <= program_page_select_d;
      watchdog_timeout_flag_q <= watchdog_timeout_flag_d;
      power_down_flag_q       <= power_down_flag_d;
      arith_q                 <= arith_d;
      read_data_q             <= (read_addr_in == CSF_FILE_ADDR) ?
                                 status_now : 8'h00;
    end
  end

  assign read_data_out           = read_data_q;
  assign status_out              = status_now;
  assign program_page_select_out = program_page_select_q;
  assign page_base_out = {program_page_select_q, 9'h000};
endmodule

// File: include/csf_pkg.sv
// shared constants for the processor status flag register
package csf_pkg;
  localparam logic [7:0] CSF_FILE_ADDR   = 8'h03;
  localparam int         CSF_BIT_WAKE    = 7;
  localparam int         CSF_BIT_UNUSED  = 6;
  localparam int         CSF_BIT_PAGE    = 5;
  localparam int         CSF_BIT_TO      = 4;
  localparam int         CSF_BIT_PD      = 3;
  localparam int         CSF_BIT_ZERO    = 2;
  localparam int         CSF_BIT_DC      = 1;
  localparam int         CSF_BIT_CARRY   = 0;
  localparam logic       CSF_RST_RW0     = 1'b0;
  localparam logic       CSF_RST_RO1     = 1'b1;
  localparam logic       CSF_RST_ARITH   = 1'b0;
  localparam logic [2:0] CSF_UPPER_CLEAR = 3'h0;
  localparam logic [8:0] CSF_PAGE_SPAN   = 9'h1ff;
  typedef enum logic [1:0]
  {
    CSF_WR_PLAIN   = 2'b00,
    CSF_WR_FLAGGED = 2'b01,
    CSF_WR_CLEAR   = 2'b11
  } csf_wr_kind_t;
endpackage

// File: sim/csf_status_reg_monitor.sv
// port assertions for the status register
module csf_status_reg_monitor
  import csf_pkg::*;
(
  input wire logic clock_in, reset_in, pin_wake_reset_in, write_en_in,
  input wire logic alu_flag_en_in, alu_zero_in, alu_dc_in, alu_carry_in,
  input wire logic watchdog_timer_expired_in, sleep_instr_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic [7:0] write_addr_in, write_data_in, read_addr_in,
  input wire csf_wr_kind_t write_kind_in,
  input wire logic [7:0] read_data_out, status_out,
  input wire logic [9:0] page_base_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire ev = watchdog_timer_expired_in | sleep_instr_in;
  wire evc = ev | watchdog_clear_instr_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence wr_s(k);
    write_en_in && write_addr_in == CSF_FILE_ADDR && write_kind_in == k;
  endsequence
  chk_reset_value: assert property ($past(reset_in) |->
    status_out == {$past(pin_wake_reset_in), 7'h18}) else $error("reset");
  chk_unused_zero: assert property (!status_out[6])
    else $error("bit 6 set");
  chk_ro_kept: assert property (
    write_en_in && !evc |=> $stable(status_out[4:3]))
    else $error("ro bit moved");
  chk_plain_write: assert property (wr_s(CSF_WR_PLAIN) |=>
    (status_out & 8'ha7) == ($past(write_data_in) & 8'ha7)) else $error("wr");
  chk_flag_protect: assert property (
    wr_s(CSF_WR_FLAGGED) ##0 alu_flag_en_in
    |=> status_out[2] == $past(alu_zero_in)) else $error("zero");
  chk_clear_file: assert property (
    wr_s(CSF_WR_CLEAR) ##0 !alu_flag_en_in |=>
    status_out[7:5] == 3'h0 && status_out[2]) else $error("clear");
  chk_expiry: assert property (
    watchdog_timer_expired_in |=> !status_out[4])
    else $error("timeout");
  chk_wdt_clear: assert property (
    watchdog_clear_instr_in && !watchdog_timer_expired_in |=>
    status_out[4:3] == 2'b11) else $error("watchdog clear");
  chk_read_other: assert property (
    read_addr_in != CSF_FILE_ADDR |=> read_data_out == 8'h00)
    else $error("read other");
  chk_page_base: assert property (page_base_out ==
    (status_out[5] ? 10'h200 : 10'h000)) else $error("page");
endmodule
bind csf_status_reg csf_status_reg_monitor mon (.*);

// File: sim/csf_core_model.sv
// core model issuing instruction writes and flag updates
module csf_core_model
  import csf_pkg::*;
(
  input  wire logic    clock_in,
  output logic         en_out = 0,
  output logic         alu_en_out = 0,
  output logic [7:0]   addr_out = 0,
  output logic [7:0]   data_out = 0,
  output csf_wr_kind_t kind_out = CSF_WR_PLAIN,
  output logic [2:0]   alu_out = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle data and alu lines show the inverse so stale data never looks valid
  task automatic issue(input logic [7:0] a, csf_wr_kind_t k, logic [7:0] d,
    logic f, logic [2:0] z);
    @(posedge clock_in);
    kind_out <= k;
    {en_out, addr_out, data_out, alu_en_out, alu_out} <= {1'b1, a, d, f, z};
    @(posedge clock_in);
    {en_out, data_out, alu_en_out, alu_out} <= {1'b0, ~d, 1'b0, ~z};
  endtask
endmodule

// File: sim/csf_status_reg_test.sv
// self-checking bench for the status register
module csf_status_reg_test import csf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, reset_in = 1, pin_wake_reset_in = 0;
  logic [2:0] ev = 0, alu_w;
  logic [7:0] read_addr_in = 8'h03, read_data_out, status_out, wa, wd;
  logic we, fe, page_sel;
  csf_wr_kind_t wk;
  int failures = 0, compares = 0;
  csf_status_reg dut (.*, .watchdog_timer_expired_in(ev[2]),
    .watchdog_clear_instr_in(ev[1]), .sleep_instr_in(ev[0]),
    .write_en_in(we), .write_addr_in(wa), .write_kind_in(wk),
    .write_data_in(wd), .alu_flag_en_in(fe), .alu_zero_in(alu_w[2]),
    .alu_dc_in(alu_w[1]), .alu_carry_in(alu_w[0]),
    .program_page_select_out(page_sel), .page_base_out());
  csf_core_model core (.clock_in, .en_out(we), .addr_out(wa), .kind_out(wk),
    .data_out(wd), .alu_en_out(fe), .alu_out(alu_w));
  initial forever #10 clock_in = ~clock_in;
  task automatic chk(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset(input logic w);
    @(posedge clock_in);
    pin_wake_reset_in <= w;
    reset_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    #1 chk(status_out, {w, 7'h18});
  endtask
  task automatic t_writes();
    core.issue(8'h03, CSF_WR_PLAIN, 8'hff, 1'b1, 3'h0);
    #1 chk(status_out, 8'hbf);
    chk({7'h00, page_sel}, 8'h01);
    core.issue(8'h04, CSF_WR_PLAIN, 8'h00, 1'b0, 3'h0);
    #1 chk(read_data_out, 8'hbf);
    core.issue(8'h03, CSF_WR_FLAGGED, 8'hff, 1'b1, 3'h2);
    #1 chk(status_out, 8'hba);
    core.issue(8'h03, CSF_WR_CLEAR, 8'hff, 1'b0, 3'h0);
    #1 chk(status_out, 8'h1e);
    chk({7'h00, page_sel}, 8'h00);
  endtask
  task automatic t_read_other();
    @(posedge clock_in);
    read_addr_in <= 8'h04;
    repeat (2) @(posedge clock_in);
    #1 chk(read_data_out, 8'h00);
    @(posedge clock_in);
    read_addr_in <= 8'h03;
    repeat (2) @(posedge clock_in);
    #1 chk(read_data_out, status_out);
  endtask
  task automatic pulse(input logic [2:0] e, input logic [7:0] exp);
    @(posedge clock_in);
    ev <= e;
    @(posedge clock_in);
    ev <= 3'h0;
    #1 chk(status_out, exp);
  endtask
  initial
  begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_writes();
    pulse(3'h4, 8'h0e);
    pulse(3'h1, 8'h16);
    pulse(3'h2, 8'h1e);
    pulse(3'h6, 8'h0e);
    t_read_other();
    wrap_up();
  end
  initial
  begin
    repeat (2000) @(posedge clock_in);
    failures++;
    wrap_up();
  end
endmodule
